// *** hw/alarm_control.sv ***
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "alarm_consts.svh"
module alarm_control (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire alarm_pkg::cal_time_t cal_time,
   input wire logic half_tick,
   input wire logic second_half,
   output logic alarm_event,
   output logic alarm_on,
   output logic irq
);
   import alarm_pkg::*;

   top_state_t r_reg;
   top_state_t r_next;
   alarm_mem_if mi ();
   logic ev;
   logic hit;

   alarm_value_mem u_mem (
      .aclk(aclk),
      .aresetn(aresetn),
      .mi(mi)
   );

   // [R9] step toward zero and stay there
   function automatic logic [1:0] ptr_step(input logic [1:0] p);
      ptr_step = (p == `PTR_MIN_SEC) ? p : p - 2'h1;
   endfunction : ptr_step

   // two-digit bcd year divisible by four: (10*t + u) mod 4 == (2*t + u) mod 4
   function automatic logic leap_bcd(input logic [7:0] y);
      logic [4:0] s;
      s = {y[6:4], 1'b0} + {1'b0, y[3:0]};
      leap_bcd = (s[1:0] == 2'h0);
   endfunction : leap_bcd

   function automatic logic alarm_match(
      input logic [3:0] ivl,
      input logic [2:0][15:0] w,
      input cal_time_t t,
      input logic half
   );
      logic sec_lo;
      logic sec_ok;
      logic min_lo;
      logic min_ok;
      logic hr_ok;
      logic wd_ok;
      logic day_ok;
      logic mon_ok;
      logic feb29;
      sec_lo = !half && t.sec[3:0] == w[`PTR_MIN_SEC][3:0];
      sec_ok = sec_lo && t.sec == w[`PTR_MIN_SEC][7:0];
      min_lo = sec_ok && t.min[3:0] == w[`PTR_MIN_SEC][11:8];
      min_ok = sec_ok && t.min == w[`PTR_MIN_SEC][15:8];
      hr_ok = min_ok && t.hour == w[`PTR_WD_HR][7:0];
      wd_ok = hr_ok && t.wday == w[`PTR_WD_HR][15:8];
      day_ok = hr_ok && t.day == w[`PTR_MON_DAY][7:0];
      mon_ok = day_ok && t.month == w[`PTR_MON_DAY][15:8];
      feb29 = w[`PTR_MON_DAY][15:8] == `MONTH_FEB && w[`PTR_MON_DAY][7:0] == `DAY_29;
      // [R5] interval decode
      case (ivl)
         `IVL_HALF: alarm_match = 1'b1;
         `IVL_SEC: alarm_match = !half;
         `IVL_SEC10: alarm_match = sec_lo;
         `IVL_MIN: alarm_match = sec_ok;
         `IVL_MIN10: alarm_match = min_lo;
         `IVL_HOUR: alarm_match = min_ok;
         `IVL_DAY: alarm_match = hr_ok;
         `IVL_WEEK: alarm_match = wd_ok;
         `IVL_MONTH: alarm_match = day_ok;
         // [R6] leap day only in leap years
         `IVL_YEAR: alarm_match = mon_ok && (!feb29 || leap_bcd(t.year));
         // [R7] reserved codes never fire
         default: alarm_match = 1'b0;
      endcase
   endfunction : alarm_match

   always_comb
   begin
      r_next = r_reg;
      r_next.event_pulse = 1'b0;
      mi.wr_en = 1'b0;
      mi.addr = r_reg.cfg.ptr;
      mi.be = s_axi_wstrb[1:0];
      mi.wdata = s_axi_wdata[15:0];

      hit = alarm_match(r_reg.cfg.ivl, mi.word, cal_time, second_half);
      // [R10] matched tick while enabled is an event
      ev = half_tick && r_reg.cfg.on && hit;
      if (ev)
      begin
         r_next.event_pulse = 1'b1;
         // [R2] [R3] count down, wrap only in chime mode
         if (r_reg.cfg.rpt != `RPT_ZERO || r_reg.cfg.chime)
            r_next.cfg.rpt = r_reg.cfg.rpt - `RPT_ONE;
         // [R1] [R4] last repeat used up
         if (r_reg.cfg.rpt == `RPT_ZERO && !r_reg.cfg.chime)
            r_next.cfg.on = 1'b0;
      end

      // write: accept address and data together, one at a time
      if (s_axi_bvalid && s_axi_bready)
         r_next.bvalid = 1'b0;
      if (!r_reg.awready && !r_reg.bvalid && s_axi_awvalid && s_axi_wvalid)
      begin
         r_next.awready = 1'b1;
         r_next.wready = 1'b1;
      end
      if (r_reg.awready)
      begin
         r_next.awready = 1'b0;
         r_next.wready = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = `RESP_OKAY;
         case (s_axi_awaddr)
            `ADDR_CFG:
            begin
               // software write wins over a same-cycle event update
               if (s_axi_wstrb[0])
                  r_next.cfg.rpt = s_axi_wdata[`CFG_RPT_HI:0];
               if (s_axi_wstrb[1])
               begin
                  r_next.cfg.on = s_axi_wdata[`CFG_ON];
                  r_next.cfg.chime = s_axi_wdata[`CFG_CHIME];
                  r_next.cfg.ivl = s_axi_wdata[`CFG_IVL_HI:`CFG_IVL_LO];
                  r_next.cfg.ptr = s_axi_wdata[`CFG_PTR_HI:`CFG_PTR_LO];
               end
            end
            `ADDR_VAL:
            begin
               // [R8] write lands in the pair the pointer selects
               mi.wr_en = 1'b1;
               // [R9] high half written
               if (s_axi_wstrb[1])
                  r_next.cfg.ptr = ptr_step(r_reg.cfg.ptr);
            end
            `ADDR_STAT:
            begin
               // status clears only by reading it
            end
            `ADDR_MASK:
            begin
               if (s_axi_wstrb[0])
                  r_next.mask = s_axi_wdata[0];
            end
            default: r_next.bresp = `RESP_SLVERR;
         endcase
      end

      // status flag: a same-cycle event beats the read-clear
      if (s_axi_rvalid && s_axi_rready)
         r_next.rvalid = 1'b0;
      r_next.arready = 1'b0;
      if (!r_reg.arready && !r_reg.rd_pend && !r_reg.rvalid && s_axi_arvalid)
         r_next.arready = 1'b1;
      r_next.rd_pend = 1'b0;
      if (r_reg.arready)
      begin
         r_next.rd_pend = 1'b1;
         r_next.rd_addr = s_axi_araddr;
      end
      if (r_reg.rd_pend)
      begin
         r_next.rvalid = 1'b1;
         r_next.rresp = `RESP_OKAY;
         r_next.rdata = 32'h0000_0000;
         case (r_reg.rd_addr)
            `ADDR_CFG: r_next.rdata = {16'h0000, r_reg.cfg};
            `ADDR_VAL:
            begin
               // [R8] pair seen through the shared port
               r_next.rdata = {16'h0000, mi.rdata};
               // [R9] whole-word read covers the high half
               r_next.cfg.ptr = ptr_step(r_reg.cfg.ptr);
            end
            `ADDR_STAT:
            begin
               r_next.rdata = {31'h0000_0000, r_reg.stat};
               r_next.stat = 1'b0;
            end
            `ADDR_MASK: r_next.rdata = {31'h0000_0000, r_reg.mask};
            default: r_next.rresp = `RESP_SLVERR;
         endcase
      end
      // [R10] event raises the sticky flag
      if (ev)
         r_next.stat = 1'b1;
      r_next.irq = r_next.stat && r_next.mask;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r_reg <= '0;
         r_reg.cfg <= `CFG_RST;
         r_reg.stat <= `STAT_RST;
         r_reg.mask <= `MASK_RST;
      end
      else
         r_reg <= r_next;
   end

   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready = r_reg.wready;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rvalid = r_reg.rvalid;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;
   assign alarm_event = r_reg.event_pulse;
   assign alarm_on = r_reg.cfg.on;
   assign irq = r_reg.irq;

endmodule : alarm_control

// *** shared/alarm_consts.svh ***
// Contract
// [R1] enable self-clears when count zero, chime off
// [R2] each alarm event decrements repeat count
// [R3] chime wraps count to all ones, else holds
// [R4] count is number of further repeats
// [R5] interval select picks the alarm period
// [R6] yearly February 29 alarm fires leap years only
// [R7] software never programs reserved interval codes
// [R8] window pointer picks value pair at port
// [R9] pointer decrements on high half access, floors
// [R10] match at interval raises event and flag
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH

`define ADDR_W 4
`define ADDR_CFG 4'h0
`define ADDR_VAL 4'h4
`define ADDR_STAT 4'h8
`define ADDR_MASK 4'hc

`define CFG_ON 15
`define CFG_CHIME 14
`define CFG_IVL_HI 13
`define CFG_IVL_LO 10
`define CFG_PTR_HI 9
`define CFG_PTR_LO 8
`define CFG_RPT_HI 7
`define CFG_RST 16'h0000
`define STAT_RST 1'h0
`define MASK_RST 1'h0

`define IVL_HALF 4'h0
`define IVL_SEC 4'h1
`define IVL_SEC10 4'h2
`define IVL_MIN 4'h3
`define IVL_MIN10 4'h4
`define IVL_HOUR 4'h5
`define IVL_DAY 4'h6
`define IVL_WEEK 4'h7
`define IVL_MONTH 4'h8
`define IVL_YEAR 4'h9

`define PTR_MIN_SEC 2'h0
`define PTR_WD_HR 2'h1
`define PTR_MON_DAY 2'h2
`define PTR_NONE 2'h3

`define RPT_ZERO 8'h00
`define RPT_ONE 8'h01
`define MONTH_FEB 8'h02
`define DAY_29 8'h29

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** shared/alarm_pkg.sv ***
package alarm_pkg;

   typedef struct packed {
      logic on;
      logic chime;
      logic [3:0] ivl;
      logic [1:0] ptr;
      logic [7:0] rpt;
   } cfg_t;

   // current calendar time, bcd fields
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] wday;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } cal_time_t;

   typedef struct packed {
      logic [2:0][15:0] word;
      logic [15:0] rdata;
   } mem_state_t;

   typedef struct packed {
      cfg_t cfg;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rd_pend;
      logic [3:0] rd_addr;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic stat;
      logic mask;
      logic irq;
      logic event_pulse;
   } top_state_t;

endpackage : alarm_pkg

// *** shared/alarm_mem_if.sv ***
`timescale 1ns/1ps
interface alarm_mem_if;
   logic wr_en;
   logic [1:0] addr;
   logic [1:0] be;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [2:0][15:0] word;

   modport ctrl (output wr_en, output addr, output be, output wdata, input rdata, input word);
   modport mem (input wr_en, input addr, input be, input wdata, output rdata, output word);
endinterface : alarm_mem_if

// *** hw/alarm_value_mem.sv ***
`timescale 1ns/1ps
`include "alarm_consts.svh"
module alarm_value_mem (
   input wire logic aclk,
   input wire logic aresetn,
   alarm_mem_if.mem mi
);
   import alarm_pkg::*;

   mem_state_t r_reg;
   mem_state_t r_next;

   always_comb
   begin
      r_next = r_reg;
      // [R8] pointer value three has no storage
      if (mi.wr_en && mi.addr != `PTR_NONE)
      begin
         if (mi.be[0])
            r_next.word[mi.addr][7:0] = mi.wdata[7:0];
         if (mi.be[1])
            r_next.word[mi.addr][15:8] = mi.wdata[15:8];
      end
      r_next.rdata = (mi.addr == `PTR_NONE) ? 16'h0000 : r_reg.word[mi.addr];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign mi.rdata = r_reg.rdata;
   assign mi.word = r_reg.word;

endmodule : alarm_value_mem

// *** tb/alarm_control_properties.sv ***
`timescale 1ns/1ps
module alarm_control_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic half_tick,
   input wire logic alarm_event,
   input wire logic alarm_on
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ev_cause_a: assert property (alarm_event |-> $past(half_tick) && $past(alarm_on))
      else $error("event without tick or enable");
   ready_pair_a: assert property (s_axi_awready |-> s_axi_wready)
      else $error("write channels taken apart");
   wr_resp_a: assert property (s_axi_awready |=> !s_axi_awready && s_axi_bvalid)
      else $error("write response late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response stuck");
   rd_resp_a: assert property (s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
      else $error("read response timing");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response stuck");
endmodule : alarm_control_properties

// *** tb/alarm_control_tb.sv ***
`timescale 1ns/1ps
`include "alarm_consts.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module alarm_control_tb;
   import alarm_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic half_tick, second_half, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, alarm_event, alarm_on, irq;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   cal_time_t cal_time, t;
   int compares, miscompares;
   alarm_control u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cal_time,
      .half_tick, .second_half, .alarm_event, .alarm_on, .irq);
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      @(posedge aclk);
      while (s_axi_awready !== 1'b1) @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask : wr
   task automatic rdv(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge aclk);
      while (s_axi_arready !== 1'b1) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask : rdv
   task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
      rdv(a);
      `CHK("rdata", e, rd)
   endtask : rdchk
   // half second pulse; the event shows in the cycle after the tick edge
   task automatic tick(input cal_time_t c, input logic sh, input logic e);
      cal_time <= c;
      second_half <= sh;
      half_tick <= 1'b1;
      @(posedge aclk);
      half_tick <= 1'b0;
      @(posedge aclk);
      `CHK("alarm_event", e, alarm_event)
   endtask : tick
   // one field per interval code 2 to 9 that that code compares and no shorter code does
   function automatic cal_time_t mis(input int k);
      mis = '0;
      case (k)
         2: mis.sec = 8'h01;
         3: mis.sec = 8'h10;
         4: mis.min = 8'h01;
         5: mis.min = 8'h10;
         6: mis.hour = 8'h01;
         7: mis.wday = 8'h01;
         8: mis.day = 8'h01;
         9: mis.month = 8'h01;
         default: ;
      endcase
   endfunction : mis
   task automatic final_report;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // whole run is a few hundred cycles
   initial
   begin
      repeat (4000) @(posedge aclk);
      miscompares++;
      final_report;
   end
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {half_tick, second_half, s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
      cal_time = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdchk(`ADDR_CFG, 32'h0);
      rdchk(`ADDR_STAT, 32'h0);
      rdchk(`ADDR_MASK, 32'h0);
      rdv(4'h2);
      `CHK("rresp", `RESP_SLVERR, rs)
      wr(4'h2, 32'hffff_ffff, 4'hf);
      `CHK("bresp", `RESP_SLVERR, rs)
      rdchk(`ADDR_CFG, 32'h0);
      wr(`ADDR_MASK, 32'h1, 4'h1);
      `CHK("bresp", `RESP_OKAY, rs)
      wr(`ADDR_CFG, 32'h8001, 4'h3);
      tick('0, 1'b1, 1'b1);
      `CHK("irq", 1'b1, irq)
      rdchk(`ADDR_CFG, 32'h8000);
      tick('0, 1'b1, 1'b1);
      rdchk(`ADDR_CFG, 32'h0000);
      `CHK("alarm_on", 1'b0, alarm_on)
      tick('0, 1'b1, 1'b0);
      // a status write must not clear the flag
      wr(`ADDR_STAT, 32'h0, 4'hf);
      `CHK("bresp", `RESP_OKAY, rs)
      rdchk(`ADDR_STAT, 32'h1);
      rdchk(`ADDR_STAT, 32'h0);
      `CHK("irq", 1'b0, irq)
      wr(`ADDR_CFG, 32'hc000, 4'h3);
      tick('0, 1'b1, 1'b1);
      rdchk(`ADDR_CFG, 32'hc0ff);
      wr(`ADDR_MASK, 32'h0, 4'h1);
      `CHK("irq", 1'b0, irq)
      wr(`ADDR_MASK, 32'h1, 4'h1);
      `CHK("irq", 1'b1, irq)
      // only defined interval codes are ever written
      for (int k = 1; k < 10; k++)
      begin
         wr(`ADDR_CFG, 32'hc0ff | (k << 10), 4'h3);
         tick('0, 1'b0, 1'b1);
         tick(mis(k), k == 1, 1'b0);
      end
      wr(`ADDR_CFG, 32'h0200, 4'h3);
      wr(`ADDR_VAL, 32'h0229, 4'h3);
      rdchk(`ADDR_CFG, 32'h0100);
      wr(`ADDR_VAL, 32'h0, 4'h3);
      wr(`ADDR_VAL, 32'h0, 4'h3);
      rdchk(`ADDR_CFG, 32'h0000);
      wr(`ADDR_CFG, 32'h0200, 4'h3);
      rdchk(`ADDR_VAL, 32'h0229);
      rdchk(`ADDR_CFG, 32'h0100);
      wr(`ADDR_CFG, 32'he4ff, 4'h3);
      t = '0;
      t.month = 8'h02;
      t.day = 8'h29;
      t.year = 8'h21;
      tick(t, 1'b0, 1'b0);
      t.year = 8'h24;
      tick(t, 1'b0, 1'b1);
      `CHK("irq", 1'b1, irq)
      `CHK("alarm_on", 1'b1, alarm_on)
      // pointer three has no storage, reads zero and still steps
      wr(`ADDR_CFG, 32'h0300, 4'h3);
      rdchk(`ADDR_VAL, 32'h0);
      rdchk(`ADDR_CFG, 32'h0200);
      // low byte only: no high half access, pointer stays
      wr(`ADDR_VAL, 32'h0, 4'h1);
      rdchk(`ADDR_CFG, 32'h0200);
      rdchk(`ADDR_VAL, 32'h0200);
      rdchk(`ADDR_CFG, 32'h0100);
      // mid-run reset with the flag and mask set
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("irq", 1'b0, irq)
      `CHK("alarm_on", 1'b0, alarm_on)
      rdchk(`ADDR_CFG, 32'h0);
      rdchk(`ADDR_STAT, 32'h0);
      rdchk(`ADDR_MASK, 32'h0);
      final_report;
   end
endmodule : alarm_control_tb
bind alarm_control alarm_control_properties u_props (.aclk, .aresetn, .s_axi_awready,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .half_tick, .alarm_event, .alarm_on);
